// *** inc/bmce_pkg.sv ***
package bmce_pkg;

   // ************************************************************
   // Bus geometry defaults.
   // ************************************************************
   localparam int ADDR_WIDTH = 32;
   localparam int DATA_WIDTH = 32;
   localparam int GRAN_WIDTH = 8;
   localparam int SEL_WIDTH = DATA_WIDTH / GRAN_WIDTH;
   localparam int LEN_WIDTH = 8;

   // ************************************************************
   // Cycle kinds requested by the user side.
   // ************************************************************
   typedef enum logic [1:0] {
      bmce_kind_single = 2'h0,
      bmce_kind_block = 2'h1,
      bmce_kind_rmw = 2'h2
   } bmce_kind_type;

   // ************************************************************
   // Response codes given back to the user side.
   // ************************************************************
   typedef enum logic [1:0] {
      bmce_resp_ok = 2'h0,
      bmce_resp_err = 2'h1,
      bmce_resp_rty = 2'h2
   } bmce_resp_type;

   // ************************************************************
   // Slave wait-state default.
   // ************************************************************
   localparam int SLAVE_WAIT = 1;

endpackage

// *** inc/bmce_if.sv ***
`timescale 1ns/1ps
interface bmce_if #(
   parameter int AW = bmce_pkg::ADDR_WIDTH,
   parameter int DW = bmce_pkg::DATA_WIDTH,
   parameter int SW = bmce_pkg::SEL_WIDTH
);
   logic [AW-1:0] adr;
   logic [DW-1:0] dat_m2s;
   logic [DW-1:0] dat_s2m;
   logic [SW-1:0] sel;
   logic we;
   logic stb;
   logic cyc;
   logic ack;
   logic err;
   logic rty;

   modport master (
      output adr,
      output dat_m2s,
      output sel,
      output we,
      output stb,
      output cyc,
      input dat_s2m,
      input ack,
      input err,
      input rty
   );

   modport slave (
      input adr,
      input dat_m2s,
      input sel,
      input we,
      input stb,
      input cyc,
      output dat_s2m,
      output ack,
      output err,
      output rty
   );
endinterface

// *** hdl/bmce_slave.sv ***
`timescale 1ns/1ps
module bmce_slave #(
   parameter int DEPTH = 16,
   parameter int WAIT = bmce_pkg::SLAVE_WAIT
) (
   input wire logic clk,
   input wire logic srst,
   bmce_if.slave bus,
   input wire logic err_req,
   input wire logic rty_req,
   output logic [bmce_pkg::DATA_WIDTH-1:0] last_wr_data,
   output logic last_wr_valid
);

   localparam int IW = $clog2(DEPTH);
   localparam int CW = $clog2(WAIT + 2);
   localparam int GW = bmce_pkg::GRAN_WIDTH;
   localparam int AL = $clog2(bmce_pkg::SEL_WIDTH);

   // ************************************************************
   // Storage and wait-state counter.
   // ************************************************************
   logic [CW-1:0] wait_reg;
   logic ack_reg;
   logic err_reg;
   logic rty_reg;
   logic [bmce_pkg::DATA_WIDTH-1:0] rdat_reg;
   wire logic [bmce_pkg::DATA_WIDTH-1:0] rd_word;
   logic [IW-1:0] idx;
   logic hit;
   logic answer;
   logic accept;

   assign idx = bus.adr[IW+AL-1:AL];
   // A transfer is recognised from cycle together with strobe; the address only picks the word. see RL2
   assign hit = bus.cyc && bus.stb && !ack_reg && !err_reg && !rty_reg;
   // The phase is answered on the edge that follows the last wait state.
   assign answer = hit && wait_reg == CW'(WAIT);
   assign accept = answer && !err_req && !rty_req;

   // Wait states stretch each phase before it is answered. see RL3
   always_ff @(posedge clk) begin
      if (srst || !hit) begin
         wait_reg <= '0;
      end else if (wait_reg != CW'(WAIT)) begin
         wait_reg <= wait_reg + 1'b1;
      end
   end

   // Answer is one cycle wide; error and retry are optional answers. see RL15
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rty_reg <= 1'b0;
      end else begin
         ack_reg <= accept;
         err_reg <= answer && err_req;
         rty_reg <= answer && !err_req && rty_req;
      end
   end

   // Write data is stored with byte selects on the same edge that raises acknowledge. see RL5
   // Each lane owns its own store, so no two processes ever write one array.
   genvar g;
   generate
      for (g = 0; g < bmce_pkg::SEL_WIDTH; g++) begin : g_lane
         logic [GW-1:0] lane_reg [DEPTH];
         always_ff @(posedge clk) begin
            if (accept && bus.we && bus.sel[g]) begin
               lane_reg[idx] <= bus.dat_m2s[g*GW +: GW];
            end
         end
         assign rd_word[g*GW +: GW] = lane_reg[idx];
      end
   endgenerate

   // Read data is presented together with acknowledge. see RL2
   always_ff @(posedge clk) begin
      if (srst) begin
         rdat_reg <= '0;
         last_wr_data <= '0;
         last_wr_valid <= 1'b0;
      end else begin
         rdat_reg <= rd_word;
         last_wr_valid <= 1'b0;
         if (accept && bus.we) begin
            last_wr_data <= bus.dat_m2s;
            last_wr_valid <= 1'b1;
         end
      end
   end

   assign bus.ack = ack_reg;
   assign bus.err = err_reg;
   assign bus.rty = rty_reg;
   assign bus.dat_s2m = rdat_reg;

endmodule

// *** hdl/bmce_master.sv ***
// Contract
// RL1: Start drives address, write, selects, strobe, cycle.
// RL2: Slave decodes strobe and address, returns data.
// RL3: Slave acknowledges, may insert wait states.
// RL4: Master samples acknowledge, captures data, drops strobe.
// RL5: Write drives data; slave acknowledges after capture.
// RL6: Block holds cycle across all phases.
// RL7: Cycle signal marks bus wanted and released.
// RL8: Read-modify-write is read then write, same place.
// RL9: Cycle stays high through both RMW phases.
// RL10: Arbiter keeps grant until cycle falls.
// RL11: Either byte order is allowed.
// RL12: Ordering matters only below operand granularity.
// RL13: Opposite orders cross-wire data and select lanes.
// RL14: Wide operands may need address adjustment.
// RL15: Answers: acknowledge, optional error, optional retry.
// RL16: No signal is bidirectional or three-state.
// RL17: Phase outputs hold steady until acknowledge.
// RL18: Reset drops strobe and cycle, goes idle.
`timescale 1ns/1ps
module bmce_master #(
   parameter bit SWAP_BYTES = 1'b0
) (
   input wire logic clk,
   input wire logic srst,
   bmce_if.master bus,
   input wire logic req_valid,
   input wire bmce_pkg::bmce_kind_type req_kind,
   input wire logic req_we,
   input wire logic [bmce_pkg::ADDR_WIDTH-1:0] req_addr,
   input wire logic [bmce_pkg::SEL_WIDTH-1:0] req_sel,
   input wire logic [bmce_pkg::DATA_WIDTH-1:0] req_wdata,
   input wire logic [bmce_pkg::DATA_WIDTH-1:0] req_rmw_mask,
   input wire logic [bmce_pkg::LEN_WIDTH-1:0] req_len,
   output logic req_ready,
   output logic rsp_valid,
   output logic [bmce_pkg::DATA_WIDTH-1:0] rsp_rdata,
   output bmce_pkg::bmce_resp_type rsp_code,
   output logic rsp_last
);

   localparam int DW = bmce_pkg::DATA_WIDTH;
   localparam int GW = bmce_pkg::GRAN_WIDTH;
   localparam int SW = bmce_pkg::SEL_WIDTH;
   // Operands never exceed the port, so each phase steps one whole port word
   // and no address rework is needed between byte orders. see RL14
   localparam logic [bmce_pkg::ADDR_WIDTH-1:0] ADDR_STEP = bmce_pkg::ADDR_WIDTH'(SW);

   typedef enum logic [2:0] {
      bmce_st_idle = 3'h1,
      bmce_st_phase = 3'h2,
      bmce_st_rmw_wr = 3'h4
   } bmce_state_type;

   // ************************************************************
   // Byte-lane helpers.
   // ************************************************************
   // Opposite byte order is a pure lane rewiring, no logic depth. see RL11 see RL12 see RL13
   function automatic logic [DW-1:0] swap_data(input logic [DW-1:0] d);
      logic [DW-1:0] r;
      r = '0;
      for (int i = 0; i < SW; i++) begin
         r[i*GW +: GW] = SWAP_BYTES ? d[(SW-1-i)*GW +: GW] : d[i*GW +: GW];
      end
      return r;
   endfunction

   function automatic logic [SW-1:0] swap_sel(input logic [SW-1:0] s);
      logic [SW-1:0] r;
      r = '0;
      for (int i = 0; i < SW; i++) begin
         r[i] = SWAP_BYTES ? s[SW-1-i] : s[i];
      end
      return r;
   endfunction

   // ************************************************************
   // State.
   // ************************************************************
   bmce_state_type state_reg;
   logic [bmce_pkg::ADDR_WIDTH-1:0] adr_reg;
   logic [DW-1:0] dat_reg;
   logic [SW-1:0] sel_reg;
   logic we_reg;
   logic stb_reg;
   logic cyc_reg;
   logic [bmce_pkg::LEN_WIDTH-1:0] left_reg;
   logic [DW-1:0] wdata_reg;
   logic [DW-1:0] mask_reg;
   logic done;
   logic [DW-1:0] rd_now;

   // Any of the three answers closes the current phase.
   assign done = stb_reg && (bus.ack || bus.err || bus.rty);
   assign rd_now = swap_data(bus.dat_s2m);

   // Sequencing of single, block and read-modify-write cycles.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_reg <= bmce_st_idle; // see RL18
         stb_reg <= 1'b0;
         cyc_reg <= 1'b0;
         we_reg <= 1'b0;
         adr_reg <= '0;
         sel_reg <= '0;
         dat_reg <= '0;
         left_reg <= '0;
         wdata_reg <= '0;
         mask_reg <= '0;
      end else begin
         case (state_reg)
            bmce_st_idle: begin
               if (req_valid) begin
                  // All phase outputs rise together on the starting edge. see RL1 see RL7
                  adr_reg <= req_addr;
                  sel_reg <= swap_sel(req_sel);
                  we_reg <= (req_kind == bmce_pkg::bmce_kind_rmw) ? 1'b0 : req_we; // see RL8
                  dat_reg <= swap_data(req_wdata); // see RL5
                  wdata_reg <= req_wdata;
                  mask_reg <= req_rmw_mask;
                  left_reg <= (req_kind == bmce_pkg::bmce_kind_block) ? req_len : '0;
                  stb_reg <= 1'b1;
                  cyc_reg <= 1'b1;
                  state_reg <= (req_kind == bmce_pkg::bmce_kind_rmw) ? bmce_st_rmw_wr : bmce_st_phase;
               end
            end
            bmce_st_phase: begin
               // Outputs hold until an answer is sampled. see RL4 see RL17
               if (done) begin
                  if (left_reg > 1 && bus.ack) begin
                     // Next phase follows back to back, cycle stays high. see RL6
                     left_reg <= left_reg - 1'b1;
                     adr_reg <= adr_reg + ADDR_STEP;
                  end else begin
                     stb_reg <= 1'b0;
                     cyc_reg <= 1'b0; // see RL6 see RL7 see RL10
                     state_reg <= bmce_st_idle;
                  end
               end
            end
            bmce_st_rmw_wr: begin
               if (done && stb_reg && !we_reg) begin
                  if (bus.ack) begin
                     // Same location written back, cycle never drops. see RL8 see RL9
                     we_reg <= 1'b1;
                     dat_reg <= swap_data((rd_now & ~mask_reg) | (wdata_reg & mask_reg));
                  end else begin
                     // A refused read phase abandons the write, so the location is left untouched.
                     stb_reg <= 1'b0;
                     cyc_reg <= 1'b0;
                     state_reg <= bmce_st_idle;
                  end
               end else if (done) begin
                  stb_reg <= 1'b0;
                  cyc_reg <= 1'b0; // see RL9
                  state_reg <= bmce_st_idle;
               end
            end
            default: begin
               state_reg <= bmce_st_idle;
               stb_reg <= 1'b0;
               cyc_reg <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Responses to the user side.
   // ************************************************************
   // Read data is captured on the answering edge. see RL4
   always_ff @(posedge clk) begin
      if (srst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         rsp_code <= bmce_pkg::bmce_resp_ok;
         rsp_last <= 1'b0;
      end else begin
         rsp_valid <= done;
         if (done) begin
            rsp_rdata <= rd_now;
            rsp_code <= bus.ack ? bmce_pkg::bmce_resp_ok :
                        (bus.err ? bmce_pkg::bmce_resp_err : bmce_pkg::bmce_resp_rty); // see RL15
            rsp_last <= !(bus.ack && ((state_reg == bmce_st_phase && left_reg > 1) ||
                                      (state_reg == bmce_st_rmw_wr && !we_reg)));
         end
      end
   end

   // Ready lags the state by one cycle and is only advisory; busy requests are ignored.
   always_ff @(posedge clk) begin
      if (srst) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= (state_reg == bmce_st_idle) && !req_valid;
      end
   end

   // ************************************************************
   // Bus outputs.
   // ************************************************************
   // Dedicated one-way outputs only, all from flip-flops. see RL16
   assign bus.adr = adr_reg;
   assign bus.dat_m2s = dat_reg;
   assign bus.sel = sel_reg;
   assign bus.we = we_reg;
   assign bus.stb = stb_reg;
   assign bus.cyc = cyc_reg;

endmodule

// *** tb/bmce_bus_properties.sv ***
`timescale 1ns/1ps
// ****
// Bus handshake checks.
// ****
module bmce_bus_properties (
   input wire logic clk,
   input wire logic srst,
   input wire logic [bmce_pkg::ADDR_WIDTH-1:0] adr,
   input wire logic [bmce_pkg::DATA_WIDTH-1:0] dat_m2s,
   input wire logic [bmce_pkg::SEL_WIDTH-1:0] sel,
   input wire logic we,
   input wire logic stb,
   input wire logic cyc,
   input wire logic ack,
   input wire logic err,
   input wire logic rty
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   stb_in_cyc_a: assert property (stb |-> cyc)
      else $error("strobe seen outside a cycle");
   phase_hold_a: assert property (stb && !(ack | err | rty) |=>
      stb && $stable(adr) && $stable(sel) && $stable(we) && $stable(dat_m2s)) else $error("phase moved early");
   answer_on_stb_a: assert property ((ack | err | rty) |-> stb)
      else $error("answer without strobe");
   answer_bound_a: assert property ($rose(stb) |-> ##[1:4] (ack | err | rty))
      else $error("answer came too late");
   one_answer_a: assert property ($onehot0({ack, err, rty}))
      else $error("two answers at once");
   strobe_drop_a: assert property (stb && ack |=> !stb || $changed(adr) || $changed(we))
      else $error("strobe held after acknowledge");
   cycle_end_a: assert property ($fell(cyc) && !$past(srst) |-> $past(ack) || $past(err) || $past(rty))
      else $error("cycle ended before last answer");
   reset_idle_a: assert property ($fell(srst) |-> !stb && !cyc)
      else $error("bus busy after reset");
   cover property (stb && ack && we);
   cover property (stb && err);
   cover property (stb && rty);
   cover property (stb && ack && !we ##1 stb && we && $stable(adr));
endmodule

// *** tb/bus_master_cycle_engine_tb.sv ***
`timescale 1ns/1ps
// ****
// Bench for master and slave joined back to back.
// ****
module bus_master_cycle_engine_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic req_valid = 1'b0;
   bmce_pkg::bmce_kind_type req_kind = bmce_pkg::bmce_kind_single;
   logic req_we = 1'b0;
   logic [31:0] req_addr = 32'h0;
   logic [31:0] req_wdata = 32'h0;
   logic [31:0] req_rmw_mask = 32'h0;
   logic [3:0] req_sel = 4'hf;
   logic [7:0] req_len = 8'h01;
   logic err_req = 1'b0;
   logic rty_req = 1'b0;
   logic req_ready;
   logic rsp_valid;
   logic rsp_last;
   logic last_wr_valid;
   logic [31:0] rsp_rdata;
   logic [31:0] last_wr_data;
   logic [31:0] swap_rdata;
   logic [31:0] swap_wr_data;
   bmce_pkg::bmce_resp_type rsp_code;
   logic [31:0] rd [0:7];
   logic [1:0] rc [0:7];
   logic rl [0:7];
   int n;
   int wn;
   int fails = 0;
   int comparisons = 0;
   bmce_if bus ();
   bmce_if bus_swap ();
   bmce_master #(.SWAP_BYTES(1'b0)) bmce_master_i (.clk(clk), .srst(srst), .bus(bus.master),
      .req_valid(req_valid), .req_kind(req_kind), .req_we(req_we), .req_addr(req_addr), .req_sel(req_sel),
      .req_wdata(req_wdata), .req_rmw_mask(req_rmw_mask), .req_len(req_len), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_code(rsp_code), .rsp_last(rsp_last));
   bmce_slave bmce_slave_i (.clk(clk), .srst(srst), .bus(bus.slave), .err_req(err_req), .rty_req(rty_req),
      .last_wr_data(last_wr_data), .last_wr_valid(last_wr_valid));
   bmce_master #(.SWAP_BYTES(1'b1)) bmce_master_swap_i (.clk(clk), .srst(srst), .bus(bus_swap.master),
      .req_valid(req_valid), .req_kind(req_kind), .req_we(req_we), .req_addr(req_addr), .req_sel(req_sel),
      .req_wdata(req_wdata), .req_rmw_mask(req_rmw_mask), .req_len(req_len), .req_ready(),
      .rsp_valid(), .rsp_rdata(swap_rdata), .rsp_code(), .rsp_last());
   bmce_slave bmce_slave_swap_i (.clk(clk), .srst(srst), .bus(bus_swap.slave), .err_req(err_req),
      .rty_req(rty_req), .last_wr_data(swap_wr_data), .last_wr_valid());
   bmce_bus_properties bmce_bus_properties_i (.clk(clk), .srst(srst), .adr(bus.adr), .dat_m2s(bus.dat_m2s),
      .sel(bus.sel), .we(bus.we), .stb(bus.stb), .cyc(bus.cyc), .ack(bus.ack), .err(bus.err), .rty(bus.rty));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One request, then responses gathered until the cycle reports its end.
   task automatic run(input bmce_pkg::bmce_kind_type k, input logic w, input logic [31:0] a,
      input logic [31:0] d, input logic [31:0] m, input logic [7:0] l);
      int t;
      n = 0;
      wn = 0;
      req_kind = k;
      req_we = w;
      req_addr = a;
      req_wdata = d;
      req_rmw_mask = m;
      req_len = l;
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      check({bus.stb, bus.cyc, bus.we, bus.sel}, {2'h3, w & (k != bmce_pkg::bmce_kind_rmw), req_sel});
      check(bus.adr, a);
      check(bus_swap.sel, {req_sel[0], req_sel[1], req_sel[2], req_sel[3]});
      for (t = 0; t < 100; t++) begin
         @(posedge clk);
         #1;
         if (last_wr_valid === 1'b1) begin
            wn++;
         end
         if (rsp_valid === 1'b1) begin
            rd[n] = rsp_rdata;
            rc[n] = rsp_code;
            rl[n] = rsp_last;
            n++;
            if (rsp_last === 1'b1 || rsp_code !== bmce_pkg::bmce_resp_ok) break;
         end
      end
      if (t == 100) begin
         fails++;
         complete_run();
      end
      @(posedge clk);
      #1;
      check({bus.cyc, bus_swap.cyc, req_ready}, 3'h1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      #1;
      srst = 1'b0;
      for (int i = 0; i < 3; i++) begin
         run(bmce_pkg::bmce_kind_single, 1'b1, 32'h10 + 4 * i, 32'ha0 + i, 32'h0, 8'h01);
         check(last_wr_data, 32'ha0 + i);
         check(wn, 1);
      end
      req_sel = 4'h1;
      run(bmce_pkg::bmce_kind_single, 1'b1, 32'h20, 32'h000000aa, 32'h0, 8'h01);
      check(last_wr_data, 32'h000000aa);
      check(swap_wr_data, 32'haa000000);
      req_sel = 4'hf;
      run(bmce_pkg::bmce_kind_single, 1'b1, 32'h8, 32'h11223344, 32'h0, 8'h01);
      check(rc[0], bmce_pkg::bmce_resp_ok);
      check(swap_wr_data, 32'h44332211);
      run(bmce_pkg::bmce_kind_single, 1'b0, 32'h8, 32'h0, 32'h0, 8'h01);
      check(rd[0], 32'h11223344);
      check(swap_rdata, 32'h11223344);
      check(wn, 0);
      run(bmce_pkg::bmce_kind_block, 1'b0, 32'h10, 32'h0, 32'h0, 8'h03);
      check(n, 3);
      check(rl[2], 1'b1);
      for (int i = 0; i < 3; i++) begin
         check(rd[i], 32'ha0 + i);
      end
      run(bmce_pkg::bmce_kind_rmw, 1'b0, 32'h8, 32'h000000ff, 32'h000000ff, 8'h01);
      check({n[3:0], rl[0], rl[1]}, 6'h09);
      check(rd[0], 32'h11223344);
      check(last_wr_data, 32'h112233ff);
      check(wn, 1);
      run(bmce_pkg::bmce_kind_single, 1'b0, 32'h8, 32'h0, 32'h0, 8'h01);
      check(rd[0], 32'h112233ff);
      err_req = 1'b1;
      run(bmce_pkg::bmce_kind_single, 1'b0, 32'h8, 32'h0, 32'h0, 8'h01);
      check(rc[0], bmce_pkg::bmce_resp_err);
      err_req = 1'b0;
      rty_req = 1'b1;
      run(bmce_pkg::bmce_kind_block, 1'b0, 32'h10, 32'h0, 32'h0, 8'h03);
      check({n[3:0], rc[0]}, {4'h1, bmce_pkg::bmce_resp_rty});
      rty_req = 1'b0;
      // A reset in mid-cycle must drop the bus at once.
      req_valid = 1'b1;
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      srst = 1'b1;
      @(posedge clk);
      #1;
      check({bus.stb, bus.cyc, bus_swap.stb, bus_swap.cyc}, 4'h0);
      srst = 1'b0;
      repeat (4) @(posedge clk);
      complete_run();
   end
endmodule
